// *** pkg/clock_reset_pkg.sv ***
// package: constants and carrier types of the core clock and reset generator
`default_nettype none
package clock_reset_pkg;

    // ************************************************************
    // register map, word addresses on the plain register port
    // ************************************************************
    localparam int         ADDR_W           = 4;
    localparam logic [3:0] CTRL_ADDR        = 4'h0;
    localparam logic [3:0] STATUS_ADDR      = 4'h4;

    // ************************************************************
    // control register fields
    // ************************************************************
    localparam int         MULT_LSB         = 0;
    localparam int         MULT_W           = 6;
    localparam int         DIVSEL_LSB       = 6;
    localparam int         DIVSEL_W         = 2;
    localparam int         INPUT_DIVIDE_ENABLE_BIT        = 8;
    localparam int         SDRATIO_LSB      = 9;
    localparam int         SDRATIO_W        = 4;

    localparam logic [1:0] DIVSEL_RESET     = 2'h0;   // divide by 2
    localparam logic [3:0] SDRATIO_RESET    = 4'h2;
    localparam logic [3:0] PERIPH_RATIO     = 4'h2;

    // multiplier chosen by the two ratio select pins
    localparam logic [5:0] MULT_SEL0        = 6'h08;
    localparam logic [5:0] MULT_SEL1        = 6'h20;
    localparam logic [5:0] MULT_SEL2        = 6'h10;
    localparam logic [5:0] MULT_SEL3        = 6'h08;

    // ************************************************************
    // status register fields
    // ************************************************************
    localparam int         STAT_CORERST_BIT = 0;
    localparam int         STAT_EXTRST_BIT  = 1;
    localparam int         STAT_CNT_LSB     = 16;
    localparam int         CNT_W            = 13;

    // ************************************************************
    // reset release timing, in reference and core cycles
    // ************************************************************
    localparam int         REF_HOLD_CYCLES  = 4096;
    localparam logic [12:0] CORE_HOLD_CYCLES = 13'h0002;

    typedef enum logic [1:0] {
        RST_EXT  = 2'b00,
        RST_REF  = 2'b01,
        RST_CORE = 2'b10,
        RST_RUN  = 2'b11
    } rst_state_e;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
    } bus_req_s;

    typedef struct packed {
        logic [MULT_W-1:0]    mult;
        logic [DIVSEL_W-1:0]  divSel;
        logic                 input_divide_enable;
        logic [SDRATIO_W-1:0] sdRatio;
    } clk_cfg_s;

endpackage
`default_nettype wire

// *** hdl/clk_enable_divider.sv ***
// module: turns a tick stream into one pulse every ratio ticks
`default_nettype none
module clk_enable_divider (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       tick,
    input  wire logic [3:0] ratio,
    output var  logic       pulse_q
);
    import clock_reset_pkg::*;

    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic       pulse_d;

    // ratio 0 behaves as 1 so the output never stalls
    always_comb begin
        cnt_d   = cnt_q;
        pulse_d = 1'b0;
        if (tick) begin
            if (cnt_q + 4'h1 >= ratio) begin
                cnt_d   = 4'h0;
                pulse_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 4'h1;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_q   <= 4'h0;
            pulse_q <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            pulse_q <= pulse_d;
        end
    end
endmodule
`default_nettype wire

// *** hdl/core_clock_reset_gen.sv ***
// module: core clock enable generation and core reset release sequencer
//
// Design decisions made here: the plain strobed port and the register offsets.
`default_nettype none
module core_clock_reset_gen #(
    parameter int REF_HOLD = clock_reset_pkg::REF_HOLD_CYCLES
) (
    input  wire logic                           mclk,
    input  wire logic                           rst,
    input  wire logic                           referenceClockInput,
    input  wire logic                           resetIn_n,
    input  wire logic [1:0]                     clockRatioSelectPins,
    input  wire clock_reset_pkg::bus_req_s      busReq,
    output var  logic [31:0]                    rdata_q,
    output var  logic                           coreClockEn_q,
    output var  logic                           periphClockEn,
    output var  logic                           sdramClockEn,
    output var  logic                           coreReset_q
);
    import clock_reset_pkg::*;

    // ************************************************************
    // helpers
    // ************************************************************
    // pin codes are read every cycle while held, so a late pin change still lands
    function automatic logic [5:0] pinMult(input logic [1:0] sel);
        case (sel)
            2'h0:    pinMult = MULT_SEL0;
            2'h1:    pinMult = MULT_SEL1;
            2'h2:    pinMult = MULT_SEL2;
            default: pinMult = MULT_SEL3;
        endcase
    endfunction

    // divider select is a power of two, so a shift replaces a table
    function automatic logic [4:0] divValue(input logic [1:0] sel);
        divValue = 5'h02 << sel;
    endfunction

    // register words are packed in one place so read and write layouts cannot drift
    function automatic logic [31:0] ctrlWord(input clk_cfg_s cfg);
        ctrlWord                           = 32'h0000_0000;
        ctrlWord[MULT_LSB +: MULT_W]       = cfg.mult;
        ctrlWord[DIVSEL_LSB +: DIVSEL_W]   = cfg.divSel;
        ctrlWord[INPUT_DIVIDE_ENABLE_BIT]                = cfg.input_divide_enable;
        ctrlWord[SDRATIO_LSB +: SDRATIO_W] = cfg.sdRatio;
    endfunction

    function automatic clk_cfg_s wordCfg(input logic [31:0] w);
        wordCfg.mult    = w[MULT_LSB +: MULT_W];
        wordCfg.divSel  = w[DIVSEL_LSB +: DIVSEL_W];
        wordCfg.input_divide_enable   = w[INPUT_DIVIDE_ENABLE_BIT];
        wordCfg.sdRatio = w[SDRATIO_LSB +: SDRATIO_W];
    endfunction

    function automatic logic [31:0] statusWord(
        input logic             coreRst,
        input logic             extLow,
        input logic [CNT_W-1:0] cnt
    );
        statusWord                        = 32'h0000_0000;
        statusWord[STAT_CORERST_BIT]      = coreRst;
        statusWord[STAT_EXTRST_BIT]       = extLow;
        statusWord[STAT_CNT_LSB +: CNT_W] = cnt;
    endfunction

    // ************************************************************
    // reference edge detect and input divider
    // ************************************************************
    logic refLast_q;
    logic refLast_d;
    logic half_q;
    logic half_d;
    logic refRise;
    logic inTick;
    logic extRstLow_q;
    logic extRstLow_d;
    clk_cfg_s cfg_q;
    clk_cfg_s cfg_d;

    // reference pin is taken as synchronous; the edge paces every count
    assign refRise = referenceClockInput & ~refLast_q;

    always_comb begin
        refLast_d   = referenceClockInput;
        extRstLow_d = ~resetIn_n;
        half_d      = half_q;
        if (refRise) begin
            half_d = ~half_q;
        end
    end

    assign inTick = refRise & (~cfg_q.input_divide_enable | half_q);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            refLast_q   <= 1'b0;
            half_q      <= 1'b0;
            extRstLow_q <= 1'b1;
        end else begin
            refLast_q   <= refLast_d;
            half_q      <= half_d;
            extRstLow_q <= extRstLow_d;
        end
    end

    // ************************************************************
    // configuration register
    // ************************************************************
    logic ctrlWrite;

    // a write while the pins own the multiplier is dropped, not queued for later
    assign ctrlWrite = busReq.wr && (busReq.addr == CTRL_ADDR);

    always_comb begin
        cfg_d = cfg_q;
        if (extRstLow_q) begin
            cfg_d.mult   = pinMult(clockRatioSelectPins);
            cfg_d.divSel = DIVSEL_RESET;
        end else if (ctrlWrite) begin
            cfg_d = wordCfg(busReq.wdata);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cfg_q.mult    <= MULT_SEL0;
            cfg_q.divSel  <= DIVSEL_RESET;
            cfg_q.input_divide_enable   <= 1'b0;
            cfg_q.sdRatio <= SDRATIO_RESET;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // ************************************************************
    // core clock enable: fractional rate multiplier over divider
    // ************************************************************
    // mclk stands in for the oscillator; core ticks are at most one per
    // mclk, so an illegal multiplier saturates rather than overflows
    logic [8:0] acc_q;
    logic [8:0] acc_d;
    logic [9:0] accSum;
    logic       coreTick;
    logic       coreClockEn_d;
    logic [4:0] div;

    // the remainder stays in the accumulator, so fractional ratios average out exactly
    always_comb begin
        div    = divValue(cfg_q.divSel);
        accSum = {1'b0, acc_q} + (inTick ? {4'h0, cfg_q.mult} : 10'h000);
        if (accSum > 10'h1ff) begin
            accSum = 10'h1ff;
        end
        coreTick = (accSum >= {5'h00, div});
        acc_d    = coreTick ? 9'(accSum - {5'h00, div}) : accSum[8:0];
        coreClockEn_d = coreTick;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            acc_q         <= 9'h000;
            coreClockEn_q <= 1'b0;
        end else begin
            acc_q         <= acc_d;
            coreClockEn_q <= coreClockEn_d;
        end
    end

    // ************************************************************
    // peripheral and sdram enables
    // ************************************************************
    clk_enable_divider periphDiv (
        .mclk    (mclk),
        .rst     (rst),
        .tick    (coreTick),
        .ratio   (PERIPH_RATIO),
        .pulse_q (periphClockEn)
    );

    clk_enable_divider sdramDiv (
        .mclk    (mclk),
        .rst     (rst),
        .tick    (coreTick),
        .ratio   (cfg_q.sdRatio),
        .pulse_q (sdramClockEn)
    );

    // ************************************************************
    // core reset release sequencer
    // ************************************************************
    rst_state_e state_q;
    rst_state_e state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             coreReset_d;

    // counting only on reference edges aligns the release to the reference;
    // a release landing just after an edge costs one extra reference cycle
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            RST_EXT: begin
                cnt_d = '0;
                if (!extRstLow_q) begin
                    state_d = RST_REF;
                end
            end
            RST_REF: begin
                if (refRise) begin
                    if (cnt_q == CNT_W'(REF_HOLD - 1)) begin
                        cnt_d   = '0;
                        state_d = RST_CORE;
                    end else begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
            end
            // the counter is reused for the two core ticks; it was cleared on entry
            RST_CORE: begin
                if (coreTick) begin
                    if (cnt_q == CORE_HOLD_CYCLES - 1'b1) begin
                        cnt_d   = '0;
                        state_d = RST_RUN;
                    end else begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
            end
            RST_RUN: begin
                cnt_d = '0;
            end
            default: begin
                state_d = RST_EXT;
                cnt_d   = '0;
            end
        endcase
        // reassertion always wins, so a half-finished hold never carries into a release
        if (extRstLow_q) begin
            state_d = RST_EXT;
            cnt_d   = '0;
        end
        coreReset_d = (state_d != RST_RUN);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q     <= RST_EXT;
            cnt_q       <= '0;
            coreReset_q <= 1'b1;
        end else begin
            state_q     <= state_d;
            cnt_q       <= cnt_d;
            coreReset_q <= coreReset_d;
        end
    end

    // ************************************************************
    // register read port
    // ************************************************************
    logic [31:0] rdata_d;

    // unread cycles return zero so a stale word is never taken for a fresh one
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (busReq.rd) begin
            case (busReq.addr)
                CTRL_ADDR: begin
                    rdata_d = ctrlWord(cfg_q);
                end
                STATUS_ADDR: begin
                    rdata_d = statusWord(coreReset_q, extRstLow_q, cnt_q);
                end
                default: begin
                    rdata_d = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end
endmodule
`default_nettype wire

// *** verification/core_clock_reset_gen_sva.sv ***
// checker: port assertions of the core clock and reset generator
`default_nettype none
module core_clock_reset_gen_sva #(
    parameter int REF_HOLD = 4096
) (
    input wire logic                      mclk,
    input wire logic                      rst,
    input wire logic                      referenceClockInput,
    input wire logic                      resetIn_n,
    input wire logic [1:0]                clockRatioSelectPins,
    input wire clock_reset_pkg::bus_req_s busReq,
    input wire logic [31:0]               rdata_q,
    input wire logic                      coreClockEn_q,
    input wire logic                      periphClockEn,
    input wire logic                      sdramClockEn,
    input wire logic                      coreReset_q
);
    timeunit 1ns;
    timeprecision 100ps;
    import clock_reset_pkg::*;
    localparam logic [5:0] MTAB [4] = '{MULT_SEL0, MULT_SEL1, MULT_SEL2, MULT_SEL3};
    int         holdCnt_q, holdCnt_d;
    logic [4:0] cntP_q, cntP_d, cntS_q, cntS_d;
    logic [3:0] sdR_q, sdR_d;
    logic       refPrev_q, extLow_q, skipS_q, skipS_d;
    // first sdram pulse after a ratio write is skipped: the divider phase is not defined then
    always_comb begin
        holdCnt_d = !resetIn_n ? 0
                  : holdCnt_q + int'(referenceClockInput && !refPrev_q && coreReset_q);
        cntP_d    = periphClockEn ? 5'h0 : cntP_q + 5'(coreClockEn_q);
        cntS_d    = sdramClockEn ? 5'h0 : cntS_q + 5'(coreClockEn_q);
        sdR_d     = sdR_q;
        skipS_d   = skipS_q && !sdramClockEn;
        if (busReq.wr && busReq.addr == CTRL_ADDR && !extLow_q) begin
            sdR_d   = busReq.wdata[SDRATIO_LSB +: SDRATIO_W];
            skipS_d = 1'b1;
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            holdCnt_q <= 0;
            cntP_q    <= 5'h0;
            cntS_q    <= 5'h0;
            sdR_q     <= SDRATIO_RESET;
            refPrev_q <= 1'b0;
            extLow_q  <= 1'b1;
            skipS_q   <= 1'b1;
        end else begin
            holdCnt_q <= holdCnt_d;
            cntP_q    <= cntP_d;
            cntS_q    <= cntS_d;
            sdR_q     <= sdR_d;
            refPrev_q <= referenceClockInput;
            extLow_q  <= !resetIn_n;
            skipS_q   <= skipS_d;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence extHeld;
        (!resetIn_n && $stable(clockRatioSelectPins))[*3];
    endsequence
    sequence ctrlRead;
        busReq.rd && busReq.addr == CTRL_ADDR;
    endsequence
    rdata_idle_a: assert property (!$past(busReq.rd) |-> rdata_q == 32'h0)
        else $error("read data outside its slot");
    mult_pins_a: assert property (
        extHeld ##0 ctrlRead |=> rdata_q[5:0] == MTAB[$past(clockRatioSelectPins)])
        else $error("multiplier not taken from ratio pins");
    div_forced_a: assert property (extHeld ##0 ctrlRead |=> rdata_q[7:6] == DIVSEL_RESET)
        else $error("divider not forced during reset");
    ext_hold_a: assert property (!resetIn_n |-> ##2 coreReset_q)
        else $error("core reset not raised by external reset");
    hold_count_a: assert property (
        $fell(coreReset_q) |-> holdCnt_q >= REF_HOLD && holdCnt_q <= REF_HOLD + 1)
        else $error("core reset hold length wrong");
    status_core_a: assert property (
        busReq.rd && busReq.addr == STATUS_ADDR |=> rdata_q[0] == $past(coreReset_q))
        else $error("status does not show core reset");
    periph_rate_a: assert property (periphClockEn |-> cntP_q + 5'(coreClockEn_q) == 5'h2)
        else $error("peripheral pulse spacing wrong");
    sdram_rate_a: assert property (sdramClockEn && !skipS_q |->
        cntS_q + 5'(coreClockEn_q) == (sdR_q == 4'h0 ? 5'h1 : 5'(sdR_q)))
        else $error("sdram pulse spacing wrong");
endmodule
bind core_clock_reset_gen core_clock_reset_gen_sva #(.REF_HOLD(REF_HOLD)) u_sva (
    .mclk, .rst, .referenceClockInput, .resetIn_n, .clockRatioSelectPins, .busReq,
    .rdata_q, .coreClockEn_q, .periphClockEn, .sdramClockEn, .coreReset_q
);
`default_nettype wire

// *** verification/ref_clock_source.sv ***
// partner: free-running reference clock source
`default_nettype none
module ref_clock_source #(
    parameter int HALF = 8
) (
    input  wire logic mclk,
    output wire logic refClk
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt = 0;
    // runs from time zero, long before any reset release
    always @(posedge mclk) begin
        cnt <= (cnt == 2 * HALF - 1) ? 0 : cnt + 1;
    end
    assign refClk = cnt >= HALF;
endmodule
`default_nettype wire

// *** verification/core_clock_reset_gen_bench.sv ***
// bench: directed tests of the core clock and reset generator
`default_nettype none
`define CHECK(g, e) begin compares++; if ((g) !== (e)) begin nFail++; \
    $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module core_clock_reset_gen_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import clock_reset_pkg::*;
    localparam int RH = 8;
    logic        mclk, rst, resetIn_n, coreClockEn_q, periphClockEn, sdramClockEn;
    logic        coreReset_q, prev;
    logic [1:0]  pins;
    bus_req_s    busReq;
    logic [31:0] rdata_q, d, cfg;
    wire  logic  refClk;
    int          nFail = 0, compares = 0, cycles = 0, n, c, pc, sc, e;
    logic [5:0]  mtab [4] = '{MULT_SEL0, MULT_SEL1, MULT_SEL2, MULT_SEL3};
    // mult, divider select, input halving, sdram ratio; all within oscillator range
    int          tc [4][4] = '{'{32, 2, 0, 4}, '{6, 1, 0, 2}, '{12, 0, 1, 8}, '{4, 3, 0, 1}};
    core_clock_reset_gen #(.REF_HOLD(RH)) u_dut (
        .mclk, .rst, .referenceClockInput(refClk), .resetIn_n, .clockRatioSelectPins(pins),
        .busReq, .rdata_q, .coreClockEn_q, .periphClockEn, .sdramClockEn, .coreReset_q
    );
    ref_clock_source #(.HALF(8)) u_ref (.mclk, .refClk);
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge mclk);
        busReq.wr    <= 1'b1;
        busReq.addr  <= a;
        busReq.wdata <= v;
        @(posedge mclk);
        busReq.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge mclk);
        busReq.rd   <= 1'b1;
        busReq.addr <= a;
        @(posedge mclk);
        busReq.rd <= 1'b0;
        #1 v = rdata_q;
    endtask
    task automatic finalReport();
        $display("compares %0d, mismatches %0d", compares, nFail);
        if (nFail == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // a run needs about 3000 cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 6000) begin
            nFail++;
            finalReport();
        end
    end
    initial begin
        rst       = 1'b1;
        resetIn_n = 1'b0;
        pins      = 2'h0;
        busReq    = '0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        // ************
        // ratio pins, writes refused while held
        // ************
        for (int p = 0; p < 4; p++) begin
            @(posedge mclk);
            pins <= 2'(p);
            wr(CTRL_ADDR, 32'h1fff);
            rd(CTRL_ADDR, d);
            `CHECK(d[12:0], {SDRATIO_RESET, 1'b0, DIVSEL_RESET, mtab[p]})
        end
        rd(STATUS_ADDR, d);
        `CHECK(d[1:0], 2'h3)
        $display("test pins done");
        // ************
        // release, abort, release again
        // ************
        @(posedge mclk);
        pins <= 2'h0;
        repeat (330) @(posedge mclk); // settings stable 20 reference periods
        resetIn_n <= 1'b1;
        repeat (200) @(posedge mclk);
        #1 `CHECK(coreReset_q, 1'b0)
        @(posedge mclk);
        resetIn_n <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 `CHECK(coreReset_q, 1'b1)
        repeat (62) @(posedge mclk);
        resetIn_n <= 1'b1; // after a low of four reference periods
        repeat (64) @(posedge mclk);
        resetIn_n <= 1'b0; // held low four reference periods
        #1 `CHECK(coreReset_q, 1'b1)
        repeat (64) @(posedge mclk);
        resetIn_n <= 1'b1;
        #1 prev = refClk;
        n = 0;
        for (int k = 0; k < 400 && coreReset_q === 1'b1; k++) begin
            @(posedge mclk);
            #1 n += int'(refClk && !prev);
            prev = refClk;
        end
        `CHECK(n >= RH && n <= RH + 1, 1'b1)
        `CHECK(coreReset_q, 1'b0)
        rd(STATUS_ADDR, d);
        `CHECK(d[1:0], 2'h0)
        rd(4'h8, d);
        `CHECK(d, 32'h0)
        $display("test release done");
        // ************
        // clock rates over 16 reference periods
        // ************
        for (int i = 0; i < 4; i++) begin
            cfg = {19'h0, 4'(tc[i][3]), 1'(tc[i][2]), 2'(tc[i][1]), 6'(tc[i][0])};
            wr(CTRL_ADDR, cfg);
            rd(CTRL_ADDR, d);
            `CHECK(d[12:0], cfg[12:0])
            repeat (256) @(posedge mclk);
            c  = 0;
            pc = 0;
            sc = 0;
            repeat (256) begin
                @(posedge mclk);
                #1 c += int'(coreClockEn_q);
                pc += int'(periphClockEn);
                sc += int'(sdramClockEn);
            end
            e = (16 >> tc[i][2]) * tc[i][0] / (2 << tc[i][1]);
            `CHECK(c, e)
            `CHECK(pc, e / 2)
            `CHECK(sc, e / tc[i][3])
        end
        $display("test rates done");
        finalReport();
    end
endmodule
`default_nettype wire
